//--- hw/bcb_pkg.sv
// ----------------------------------------------------------------------------
// Behaviour
// - Bit set forces chosen bit of memory nibble at pointer to one.
// - Bit clear forces chosen bit to zero; one word, one cycle.
// - Bit zero test skips the next instruction when the chosen bit is zero.
// - Accumulator equal to memory nibble skips next; one word, one cycle.
// - Immediate compare: two words, two cycles; skip when accumulator equals constant.
// - Near jump loads 7-bit offset, page unchanged; one word, one cycle.
// - Far jump: two words, loads page and 7-bit offset.
// - Indexed near jump target is upper three address bits plus accumulator.
// - Indexed far jump loads page, upper three address bits plus accumulator.
// - Pages zero to seven are reachable by far jump forms.
// - None of these instructions alters the carry flag.
// ----------------------------------------------------------------------------
package bcb_pkg;

  // --------------------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------------------
  localparam int WORD_W = 9;
  localparam int NIB_W  = 4;
  localparam int OFS_W  = 7;
  localparam int PAGE_W = 3;

  // --------------------------------------------------------------------------
  // Opcode patterns and masks
  // --------------------------------------------------------------------------
  localparam logic [WORD_W-1:0] PAT_BIT_SET   = 9'h05c;
  localparam logic [WORD_W-1:0] PAT_BIT_CLEAR = 9'h04c;
  localparam logic [WORD_W-1:0] PAT_BIT_ZERO  = 9'h020;
  localparam logic [WORD_W-1:0] MSK_BIT       = 9'h1fc;
  localparam logic [WORD_W-1:0] PAT_ACC_MEM   = 9'h026;
  localparam logic [WORD_W-1:0] PAT_ACC_IMM   = 9'h025;
  localparam logic [WORD_W-1:0] PAT_NEAR      = 9'h180;
  localparam logic [WORD_W-1:0] MSK_NEAR      = 9'h180;
  localparam logic [WORD_W-1:0] PAT_FAR       = 9'h030;
  localparam logic [WORD_W-1:0] MSK_FAR       = 9'h1f0;
  localparam logic [WORD_W-1:0] PAT_IDX_NEAR  = 9'h001;
  localparam logic [WORD_W-1:0] PAT_IDX_FAR   = 9'h010;
  localparam logic [WORD_W-1:0] MSK_FULL      = 9'h1ff;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int BIT_SEL_LSB = 0;
  localparam int IMM_LSB     = 0;
  localparam int OFS_LSB     = 0;
  localparam int PAGE_LSB    = 0;
  localparam int OFS_HI_LSB  = 4;

  // --------------------------------------------------------------------------
  // Operation classes
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    BCB_OTHER_OP,
    BCB_BIT_SET_OP,
    BCB_BIT_CLEAR_OP,
    BCB_BIT_ZERO_SKIP_OP,
    BCB_ACC_MEM_EQUAL_SKIP_OP,
    BCB_ACC_IMM_EQUAL_SKIP_OP,
    BCB_NEAR_JUMP_OP,
    BCB_FAR_JUMP_OP,
    BCB_ACC_INDEXED_NEAR_JUMP_OP,
    BCB_ACC_INDEXED_FAR_JUMP_OP
  } bcb_op_t;

endpackage

//--- hw/bcb_dec_if.sv
`timescale 1ns/1ps
// Carries one instruction word to the classifier and its decoded fields back.
interface bcb_dec_if;
  import bcb_pkg::*;
  logic [WORD_W-1:0] word;
  bcb_op_t           op;
  logic [1:0]        bit_sel;
  logic [NIB_W-1:0]  imm;
  logic [OFS_W-1:0]  ofs;
  logic [PAGE_W-1:0] page;
  logic              two_word;

  modport dec (input word, output op, bit_sel, imm, ofs, page, two_word);
  modport use_side (output word, input op, bit_sel, imm, ofs, page, two_word);
endinterface

//--- hw/bcb_decoder.sv
`timescale 1ns/1ps
module bcb_decoder
  import bcb_pkg::*;
(
  // Decode channel
  bcb_dec_if.dec dif
);

  // --------------------------------------------------------------------------
  // Classification
  // --------------------------------------------------------------------------

  // Masked compares; the near jump pattern is tested last because its mask is narrowest.
  always_comb begin
    dif.op = BCB_OTHER_OP;
    if ((dif.word & MSK_BIT) == PAT_BIT_SET) begin
      dif.op = BCB_BIT_SET_OP;
    end else if ((dif.word & MSK_BIT) == PAT_BIT_CLEAR) begin
      dif.op = BCB_BIT_CLEAR_OP;
    end else if ((dif.word & MSK_BIT) == PAT_BIT_ZERO) begin
      dif.op = BCB_BIT_ZERO_SKIP_OP;
    end else if ((dif.word & MSK_FULL) == PAT_ACC_MEM) begin
      dif.op = BCB_ACC_MEM_EQUAL_SKIP_OP;
    end else if ((dif.word & MSK_FULL) == PAT_ACC_IMM) begin
      dif.op = BCB_ACC_IMM_EQUAL_SKIP_OP;
    end else if ((dif.word & MSK_FAR) == PAT_FAR) begin
      dif.op = BCB_FAR_JUMP_OP;
    end else if ((dif.word & MSK_FULL) == PAT_IDX_NEAR) begin
      dif.op = BCB_ACC_INDEXED_NEAR_JUMP_OP;
    end else if ((dif.word & MSK_FULL) == PAT_IDX_FAR) begin
      dif.op = BCB_ACC_INDEXED_FAR_JUMP_OP;
    end else if ((dif.word & MSK_NEAR) == PAT_NEAR) begin
      dif.op = BCB_NEAR_JUMP_OP;
    end
  end

  // Field extraction; only three page bits exist, so the top page bit is dropped.
  assign dif.bit_sel  = dif.word[BIT_SEL_LSB +: 2];
  assign dif.imm      = dif.word[IMM_LSB +: NIB_W];
  assign dif.ofs      = dif.word[OFS_LSB +: OFS_W];
  assign dif.page     = dif.word[PAGE_LSB +: PAGE_W];
  assign dif.two_word = (dif.op == BCB_ACC_IMM_EQUAL_SKIP_OP) || (dif.op == BCB_FAR_JUMP_OP) ||
                        (dif.op == BCB_ACC_INDEXED_NEAR_JUMP_OP) || (dif.op == BCB_ACC_INDEXED_FAR_JUMP_OP);

endmodule

//--- hw/bcb_exec.sv
`timescale 1ns/1ps
module bcb_exec
  import bcb_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Fetched instruction
  input  wire logic              instr_valid,
  input  wire logic [WORD_W-1:0] instr_word,
  // Core operands
  input  wire logic [NIB_W-1:0]  acc,
  input  wire logic [NIB_W-1:0]  mem_rdata,
  // Data memory write at the data pointer
  output logic                   mem_we,
  output logic [NIB_W-1:0]       mem_wdata,
  // Program counter loads
  output logic                   pc_offset_load,
  output logic [OFS_W-1:0]       pc_offset_part,
  output logic                   pc_page_load,
  output logic [PAGE_W-1:0]      pc_page_part,
  // Status
  output logic                   skip_pending,
  output logic                   skipped,
  output logic                   second_word,
  output logic                   carry_flag_we
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------

  // The pending class remembers a two-word opener until its operand word is taken.
  // skip_second marks that operand word as one to swallow because its opener was skipped.
  // Data outputs hold their last value, so only the pulse fields are cleared each cycle.
  typedef struct packed {
    bcb_op_t           pend;
    logic [PAGE_W-1:0] pend_page;
    logic              skip_next;
    logic              skip_second;
    logic              mem_we;
    logic [NIB_W-1:0]  mem_wdata;
    logic              ofs_load;
    logic [OFS_W-1:0]  ofs;
    logic              page_load;
    logic [PAGE_W-1:0] page;
    logic              skipped;
    logic              second;
    logic              carry_we;
  } bcb_state_t;

  // Reset clears every field, so no half-taken form and no skip survives a reset.
  localparam bcb_state_t RESET_STATE = '{
    pend:        BCB_OTHER_OP,
    pend_page:   '0,
    skip_next:   1'b0,
    skip_second: 1'b0,
    mem_we:      1'b0,
    mem_wdata:   '0,
    ofs_load:    1'b0,
    ofs:         '0,
    page_load:   1'b0,
    page:        '0,
    skipped:     1'b0,
    second:      1'b0,
    carry_we:    1'b0
  };

  bcb_state_t s;
  bcb_state_t next_s;
  bcb_dec_if  dif ();

  // --------------------------------------------------------------------------
  // Decoder
  // --------------------------------------------------------------------------
  // The decoder is pure logic; the word is classified in the cycle in which it is taken.
  assign dif.word = instr_word;

  bcb_decoder u_dec (
    .dif (dif.dec)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------

  // Writes and loads are one-cycle pulses registered after the word is taken; skip_next holds until the next word.
  // Memory is read-modify-write of the nibble at the pointer, so the other bits
  // come from mem_rdata in the same cycle.
  always_comb begin
    logic [NIB_W-1:0] set_val;
    logic [NIB_W-1:0] clr_val;
    set_val = mem_rdata;
    clr_val = mem_rdata;
    set_val[dif.bit_sel] = 1'b1;
    clr_val[dif.bit_sel] = 1'b0;
    next_s           = s;
    // Pulses default low; the data fields keep their value until the next load.
    next_s.mem_we    = 1'b0;
    next_s.ofs_load  = 1'b0;
    next_s.page_load = 1'b0;
    next_s.skipped   = 1'b0;
    next_s.second    = 1'b0;
    // The carry write enable is kept for the core's sake and is never raised here.
    next_s.carry_we  = 1'b0;
    // A cycle without a fetched word changes nothing but the pulses.
    if (instr_valid) begin
      if (s.pend != BCB_OTHER_OP) begin
        // Second word; whatever arrives is taken as the operand word.
        next_s.pend        = BCB_OTHER_OP;
        next_s.second      = 1'b1;
        next_s.skip_second = 1'b0;
        next_s.skipped     = s.skip_second;
        if (!s.skip_second) begin
          // The operand word is not checked against its own pattern; the core guarantees
          // the pairing, and checking it would cost a second decoder for no gain.
          case (s.pend)
            BCB_ACC_IMM_EQUAL_SKIP_OP: begin
              // A match skips the word after the operand, not the operand itself.
              next_s.skip_next = (acc == dif.imm);
            end
            BCB_FAR_JUMP_OP: begin
              // The page was latched from the opener; the offset comes from this word.
              next_s.page_load = 1'b1;
              next_s.page      = s.pend_page;
              next_s.ofs_load  = 1'b1;
              next_s.ofs       = dif.ofs;
            end
            BCB_ACC_INDEXED_NEAR_JUMP_OP: begin
              // Only the upper three offset bits come from the word; acc fills the rest.
              next_s.ofs_load = 1'b1;
              next_s.ofs      = {dif.ofs[OFS_HI_LSB +: OFS_W-NIB_W], acc};
            end
            BCB_ACC_INDEXED_FAR_JUMP_OP: begin
              // The accumulator is sampled with the operand word, not with the opener.
              next_s.page_load = 1'b1;
              next_s.page      = dif.page;
              next_s.ofs_load  = 1'b1;
              next_s.ofs       = {dif.ofs[OFS_HI_LSB +: OFS_W-NIB_W], acc};
            end
            default: begin
              next_s.pend = BCB_OTHER_OP;
            end
          endcase
        end
      end else if (s.skip_next) begin
        // Skipped word: no effect, but a two-word opener also swallows its operand.
        // Skipped words never start a skip of their own, so compares cannot chain.
        next_s.skip_next = 1'b0;
        next_s.skipped   = 1'b1;
        if (dif.two_word) begin
          next_s.pend        = dif.op;
          next_s.skip_second = 1'b1;
        end
      end else begin
        // First word of an instruction; single-word forms act at once.
        // Bit forms rely on mem_rdata being the nibble at the data pointer in this cycle.
        case (dif.op)
          BCB_BIT_SET_OP: begin
            next_s.mem_we    = 1'b1;
            next_s.mem_wdata = set_val;
          end
          BCB_BIT_CLEAR_OP: begin
            next_s.mem_we    = 1'b1;
            next_s.mem_wdata = clr_val;
          end
          BCB_BIT_ZERO_SKIP_OP: begin
            next_s.skip_next = ~mem_rdata[dif.bit_sel];
          end
          BCB_ACC_MEM_EQUAL_SKIP_OP: begin
            next_s.skip_next = (acc == mem_rdata);
          end
          BCB_NEAR_JUMP_OP: begin
            next_s.ofs_load = 1'b1;
            next_s.ofs      = dif.ofs;
          end
          BCB_FAR_JUMP_OP: begin
            // Only the page is kept; the offset arrives with the second word.
            next_s.pend      = dif.op;
            next_s.pend_page = dif.page;
          end
          BCB_ACC_IMM_EQUAL_SKIP_OP,
          BCB_ACC_INDEXED_NEAR_JUMP_OP,
          BCB_ACC_INDEXED_FAR_JUMP_OP: begin
            next_s.pend = dif.op;
          end
          default: begin
            // Words outside this group have no effect here.
            next_s.pend = BCB_OTHER_OP;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------

  // Synchronous reset leaves nothing pending, so the first word after reset executes.
  // A reset in the middle of a two-word form drops the opener without any effect.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state flops.
  // Nothing is combinational on the way out, so the core sees settled values.
  assign mem_we         = s.mem_we;
  assign mem_wdata      = s.mem_wdata;
  assign pc_offset_load = s.ofs_load;
  assign pc_offset_part = s.ofs;
  assign pc_page_load   = s.page_load;
  assign pc_page_part   = s.page;
  assign skip_pending   = s.skip_next;
  assign skipped        = s.skipped;
  assign second_word    = s.second;
  assign carry_flag_we  = s.carry_we;

endmodule

//--- tb/bcb_exec_monitor.sv
`timescale 1ns/1ps
module bcb_exec_monitor
  import bcb_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst,
  // Inputs
  input wire logic              instr_valid,
  input wire logic [WORD_W-1:0] instr_word,
  input wire logic [NIB_W-1:0]  acc,
  input wire logic [NIB_W-1:0]  mem_rdata,
  // Outputs
  input wire logic              mem_we,
  input wire logic [NIB_W-1:0]  mem_wdata,
  input wire logic              pc_offset_load,
  input wire logic [OFS_W-1:0]  pc_offset_part,
  input wire logic              pc_page_load,
  input wire logic [PAGE_W-1:0] pc_page_part,
  input wire logic              skip_pending,
  input wire logic              skipped,
  input wire logic              second_word,
  input wire logic              carry_flag_we
);
  logic             opnd;
  logic             first;
  logic             sel_bit;
  logic [NIB_W-1:0] set_val;
  logic [NIB_W-1:0] clr_val;

  // Operand tracking, so a bit pattern used as an operand never triggers a check.
  always_ff @(posedge mclk) begin
    if (rst) begin
      opnd <= 1'b0;
    end else if (instr_valid) begin
      opnd <= !opnd && (instr_word == PAT_ACC_IMM || (instr_word & MSK_FAR) == PAT_FAR ||
                        instr_word == PAT_IDX_NEAR || instr_word == PAT_IDX_FAR);
    end
  end

  // Expected memory results, computed from the sampled nibble.
  assign first   = instr_valid && !opnd && !skip_pending;
  assign sel_bit = mem_rdata[instr_word[1:0]];
  assign set_val = mem_rdata | (4'h1 << instr_word[1:0]);
  assign clr_val = mem_rdata & ~(4'h1 << instr_word[1:0]);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  carry_kept_a: assert property (!carry_flag_we) else $error("carry written");
  bit_set_a: assert property (
    first && (instr_word & MSK_BIT) == PAT_BIT_SET |=> mem_we && mem_wdata == $past(set_val))
    else $error("bit set wrong");
  bit_clear_a: assert property (
    first && (instr_word & MSK_BIT) == PAT_BIT_CLEAR |=> mem_we && mem_wdata == $past(clr_val))
    else $error("bit clear wrong");
  zero_test_a: assert property (
    first && (instr_word & MSK_BIT) == PAT_BIT_ZERO |=> skip_pending == !$past(sel_bit))
    else $error("bit test skip wrong");
  acc_mem_a: assert property (
    first && instr_word == PAT_ACC_MEM |=> skip_pending == ($past(acc) == $past(mem_rdata)))
    else $error("compare skip wrong");
  operand_a: assert property (opnd && instr_valid |=> second_word)
    else $error("operand word not consumed");
  near_jump_a: assert property (
    first && (instr_word & MSK_NEAR) == PAT_NEAR |=>
    pc_offset_load && !pc_page_load && pc_offset_part == $past(instr_word[6:0]))
    else $error("near jump wrong");
  page_with_ofs_a: assert property (pc_page_load |-> pc_offset_load)
    else $error("page load alone");
  skip_taken_a: assert property (instr_valid && skip_pending |=> skipped)
    else $error("word not suppressed");
  skip_quiet_a: assert property (skipped |-> !mem_we && !pc_offset_load && !pc_page_load)
    else $error("suppressed word had effect");

  // Main scenarios.
  cover property (skipped && second_word);
  cover property (pc_page_load && second_word);
  cover property (mem_we);
endmodule

bind bcb_exec bcb_exec_monitor u_bcb_exec_monitor (.mclk, .rst, .instr_valid, .instr_word, .acc,
  .mem_rdata, .mem_we, .mem_wdata, .pc_offset_load, .pc_offset_part, .pc_page_load,
  .pc_page_part, .skip_pending, .skipped, .second_word, .carry_flag_we);

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import bcb_pkg::*;
  logic              mclk;
  logic              rst;
  logic              instr_valid;
  logic [WORD_W-1:0] instr_word;
  logic [NIB_W-1:0]  acc;
  logic [NIB_W-1:0]  mem_rdata;
  logic              mem_we;
  logic [NIB_W-1:0]  mem_wdata;
  logic              pc_offset_load;
  logic [OFS_W-1:0]  pc_offset_part;
  logic              pc_page_load;
  logic [PAGE_W-1:0] pc_page_part;
  logic              skip_pending;
  logic              skipped;
  logic              second_word;
  logic              carry_flag_we;
  int                fails = 0;
  int                check_count = 0;
  int                cycles = 0;

  bcb_exec u_bcb_exec (.mclk, .rst, .instr_valid, .instr_word, .acc, .mem_rdata, .mem_we,
    .mem_wdata, .pc_offset_load, .pc_offset_part, .pc_page_load, .pc_page_part,
    .skip_pending, .skipped, .second_word, .carry_flag_we);

  // Clock and a hang guard; the run needs under a hundred cycles.
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Presents one word; effects are registered, so they are judged one edge later.
  task automatic take(input logic [8:0] w, input logic [3:0] a, input logic [3:0] m);
    instr_valid = 1'b1;
    instr_word = w;
    acc = a;
    mem_rdata = m;
    @(posedge mclk);
    #1;
  endtask

  // Pulse order: write, offset load, page load, suppressed, operand word.
  task automatic pul(input logic [4:0] e);
    chk("pulses", {4'h0, mem_we, pc_offset_load, pc_page_load, skipped, second_word}, {4'h0, e});
  endtask

  task automatic skp(input logic e);
    chk("skip_pending", {8'h0, skip_pending}, {8'h0, e});
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_bits();
    for (int j = 0; j < 4; j++) begin
      take(PAT_BIT_SET | 9'(j), 4'h0, 4'ha);
      pul(5'h10);
      chk("set_data", {5'h0, mem_wdata}, 9'(4'ha | (4'h1 << j)));
      take(PAT_BIT_CLEAR | 9'(j), 4'h0, 4'hf);
      pul(5'h10);
      chk("clear_data", {5'h0, mem_wdata}, 9'(4'hf & ~(4'h1 << j)));
      chk("carry_we", {8'h0, carry_flag_we}, 9'h0);
    end
  endtask

  task automatic t_zero();
    for (int j = 0; j < 4; j++) begin
      take(PAT_BIT_ZERO | 9'(j), 4'h0, 4'hf ^ (4'h1 << j));
      skp(1'b1);
      take(PAT_NEAR | 9'h55, 4'h0, 4'h0);
      pul(5'h02);
      take(PAT_BIT_ZERO | 9'(j), 4'h0, 4'h1 << j);
      skp(1'b0);
    end
  endtask

  // Equal compare skips a whole far jump; unequal lets a near jump through.
  task automatic t_acc_mem();
    take(PAT_ACC_MEM, 4'h9, 4'h9);
    skp(1'b1);
    take(PAT_FAR | 9'h2, 4'h0, 4'h0);
    pul(5'h02);
    take(PAT_NEAR | 9'h11, 4'h0, 4'h0);
    pul(5'h03);
    take(PAT_ACC_MEM, 4'h9, 4'h8);
    skp(1'b0);
    take(PAT_NEAR | 9'h11, 4'h0, 4'h0);
    pul(5'h08);
    chk("near_ofs", {2'h0, pc_offset_part}, 9'h11);
  endtask

  task automatic t_imm();
    for (int n = 0; n < 16; n += 5) begin
      take(PAT_ACC_IMM, 4'(n), 4'h0);
      skp(1'b0);
      take(9'h0b0 | 9'(n), 4'(n), 4'h0);
      pul(5'h01);
      skp(1'b1);
      take(PAT_NEAR | 9'h7f, 4'h0, 4'h0);
      pul(5'h02);
      take(PAT_ACC_IMM, 4'(n + 1), 4'h0);
      take(9'h0b0 | 9'(n), 4'(n + 1), 4'h0);
      skp(1'b0);
    end
  endtask

  // Every page, then both accumulator-indexed forms.
  task automatic t_jumps();
    for (int p = 0; p < 8; p++) begin
      take(PAT_FAR | 9'(p), 4'h0, 4'h0);
      pul(5'h00);
      take(PAT_NEAR | 9'(7'h40 + p), 4'h0, 4'h0);
      pul(5'h0d);
      chk("far_page", {6'h0, pc_page_part}, 9'(p));
      chk("far_ofs", {2'h0, pc_offset_part}, 9'(7'h40 + p));
    end
    take(PAT_IDX_NEAR, 4'h0, 4'h0);
    take(9'h1f5, 4'ha, 4'h0);
    pul(5'h09);
    chk("idx_near_ofs", {2'h0, pc_offset_part}, 9'h07a);
    take(PAT_IDX_FAR, 4'h0, 4'h0);
    take(9'h1d5, 4'h3, 4'h0);
    pul(5'h0d);
    chk("idx_far_page", {6'h0, pc_page_part}, 9'h005);
    chk("idx_far_ofs", {2'h0, pc_offset_part}, 9'h053);
  endtask

  // A reset in mid-run drops a pending skip and a half-taken far jump.
  task automatic t_reset();
    take(PAT_ACC_MEM, 4'h5, 4'h5);
    skp(1'b1);
    rst = 1'b1;
    instr_valid = 1'b0;
    @(posedge mclk);
    #1;
    rst = 1'b0;
    skp(1'b0);
    take(PAT_FAR | 9'h3, 4'h0, 4'h0);
    rst = 1'b1;
    instr_valid = 1'b0;
    @(posedge mclk);
    #1;
    rst = 1'b0;
    pul(5'h00);
    chk("reset_page", {6'h0, pc_page_part}, 9'h0);
    take(PAT_NEAR | 9'h22, 4'h0, 4'h0);
    pul(5'h08);
    chk("reset_ofs", {2'h0, pc_offset_part}, 9'h22);
  endtask

  // Reset, then the scenarios back to back.
  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = '0;
    acc = '0;
    mem_rdata = '0;
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_bits();
    t_zero();
    t_acc_mem();
    t_imm();
    t_jumps();
    t_reset();
    instr_valid = 1'b0;
    @(posedge mclk);
    #1;
    pul(5'h00);
    tally_and_finish();
  end
endmodule
